// [logic/adcseq_consts.vh]
// Constants for the converter control sequencer
`ifndef ADCSEQ_CONSTS_VH
`define ADCSEQ_CONSTS_VH

// Control/status register bit positions
`define ADCSEQ_CSR_END_FLAG   7
`define ADCSEQ_CSR_IRQ_EN     6
`define ADCSEQ_CSR_START      5
`define ADCSEQ_CSR_SCAN       4
`define ADCSEQ_CSR_SPEED      3
`define ADCSEQ_CSR_GROUP      2
`define ADCSEQ_CSR_CH_HI      1
`define ADCSEQ_CSR_CH_LO      0
`define ADCSEQ_CSR_RESET      8'h00

// Trigger control register
`define ADCSEQ_TRG_ENABLE     7
`define ADCSEQ_TRG_RESERVED   7'h7F

// Result layout
`define ADCSEQ_RES_BITS       10
`define ADCSEQ_RES_RESET      10'h000
`define ADCSEQ_LOW_PAD        6'h00
`define ADCSEQ_MSB_POS        4'h9
`define ADCSEQ_CODE_MID       10'h200

// Timing in states (one state is one clock)
`define ADCSEQ_SYNC_SLOW      5'h0A
`define ADCSEQ_SYNC_FAST      5'h06
`define ADCSEQ_SAMPLE_SLOW    9'h050
`define ADCSEQ_SAMPLE_FAST    9'h028
`define ADCSEQ_STEP_SLOW      5'h10
`define ADCSEQ_STEP_FAST      5'h08
`define ADCSEQ_CONV_SLOW      9'h100
`define ADCSEQ_CONV_FAST      9'h080

// Sequencer states
`define ADCSEQ_ST_IDLE        2'h0
`define ADCSEQ_ST_SYNC        2'h1
`define ADCSEQ_ST_CONV        2'h2

`endif

// [logic/adcseq_sar.v]
// Successive-approximation engine: sample window, ten bit decisions, done pulse
`timescale 1ns/1ps
`default_nettype none
`include "adcseq_consts.vh"

module adcseq_sar (
  input  wire        sys_clk_i,
  input  wire        rst_i,
  input  wire        start_i,
  input  wire        abort_i,
  input  wire        speed_i,
  input  wire        comp_gt_i,
  output wire        sample_hold_o,
  output wire [9:0]  dac_code_o,
  output wire        done_o,
  output reg  [9:0]  result_o
);

  reg        busy;
  reg  [8:0] cnt;
  reg  [4:0] step_cnt;
  reg  [3:0] bitpos;
  reg        bits_left;
  reg  [9:0] code;

  wire [8:0] sample_len = speed_i ? `ADCSEQ_SAMPLE_FAST : `ADCSEQ_SAMPLE_SLOW;
  wire [4:0] step_len   = speed_i ? `ADCSEQ_STEP_FAST : `ADCSEQ_STEP_SLOW;
  wire [8:0] conv_len   = speed_i ? `ADCSEQ_CONV_FAST : `ADCSEQ_CONV_SLOW;
  wire       sampling   = busy && (cnt < sample_len);
  wire       decide     = busy && !sampling && bits_left && (step_cnt == step_len - 5'h01);
  wire [9:0] trial_bit  = 10'h001 << bitpos;

  assign sample_hold_o = sampling; // [R12]
  assign dac_code_o    = code;
  // Ends exactly conv_len states after start, so back-to-back scans stay periodic
  assign done_o        = busy && (cnt == conv_len - 9'h001); // [R14]

  always @(posedge sys_clk_i) begin
    if (rst_i || abort_i) begin
      busy      <= 1'b0;
      cnt       <= 9'h000;
      step_cnt  <= 5'h00;
      bitpos    <= `ADCSEQ_MSB_POS;
      bits_left <= 1'b0;
      code      <= 10'h000;
    end else if (start_i) begin
      busy      <= 1'b1;
      cnt       <= 9'h000;
      step_cnt  <= 5'h00;
      bitpos    <= `ADCSEQ_MSB_POS;
      bits_left <= 1'b1;
      code      <= `ADCSEQ_CODE_MID;
    end else if (busy) begin
      cnt <= cnt + 9'h001;
      if (done_o) begin
        busy <= 1'b0;
      end
      if (!sampling) begin
        step_cnt <= (step_cnt == step_len - 5'h01) ? 5'h00 : step_cnt + 5'h01;
      end
      if (decide) begin // [R1]
        if (bitpos == 4'h0) begin
          bits_left <= 1'b0;
          code      <= comp_gt_i ? code : (code & ~trial_bit);
        end else begin
          bitpos <= bitpos - 4'h1;
          code   <= (comp_gt_i ? code : (code & ~trial_bit)) | (trial_bit >> 1);
        end
      end
    end
  end

  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      result_o <= `ADCSEQ_RES_RESET;
    end else if (busy && !bits_left) begin
      result_o <= code;
    end
  end

endmodule // adcseq_sar

`default_nettype wire

// [logic/adcseq_top.v]
// Converter control sequencer: control/status, trigger, channel scan, result registers
`timescale 1ns/1ps
`default_nettype none
`include "adcseq_consts.vh"

// How it works
// R1: Each sample resolves by successive approximation to 10 bits; single or scan mode.
// R2: In single mode the start bit stays set until the conversion completes.
// R3: Completion sets the end flag; interrupt request follows when enabled.
// R4: End flag clears only by reading status while set, then writing zero.
// R5: Single completion stores result, sets flag, clears start together, then idles.
// R6: Software clears start before changing mode or channel; may restart same write.
// R7: Scan start begins at input 0 or input 4 per group select.
// R8: Scan converts channels back to back, storing each, until start clears.
// R9: Scan sets end flag after the last channel and restarts the first at once.
// R10: Clearing start stops scan; restart always begins from group's first channel.
// R11: Sampling follows a synchronisation delay after start is set.
// R12: Sampling window is 80 states slow, 40 states fast.
// R13: First conversion takes 259-266 states slow, 131-134 fast, delay included.
// R14: Later scan conversions take exactly 256 or 128 states.
// R15: With trigger enabled, falling edge on trigger pin sets start bit.
// R16: Triggered start behaves exactly like a software start.
// R17: Result upper byte holds top 8 bits; bits 7-6 low two, rest zero.
// R18: Upper-byte read latches low byte into temp; later low read returns it.
// R19: Channel field picks one input, or in scan a group and channel count.
// R20: Status and results reset to zero; trigger register resets with reserved ones.
// R21: Clearing start mid-conversion aborts without touching result or flag.
module adcseq_top (
  input  wire        sys_clk_i,
  input  wire        rst_i,
  input  wire        standby_i,
  input  wire        ctrl_write_i,
  input  wire [7:0]  ctrl_wdata_i,
  input  wire        ctrl_read_i,
  output wire [7:0]  conv_control_status_reg_o,
  input  wire        trig_write_i,
  input  wire [7:0]  trig_wdata_i,
  output wire [7:0]  trigger_control_reg_o,
  input  wire        result_read_i,
  input  wire [1:0]  result_sel_i,
  input  wire        result_upper_i,
  output reg  [7:0]  result_byte_o,
  input  wire        ext_trigger_pin_n_i,
  input  wire        comp_gt_i,
  output wire [2:0]  analog_sel_o,
  output wire        sample_hold_o,
  output wire [9:0]  dac_code_o,
  output wire        conv_start_bit_o,
  output wire        conv_end_flag_o,
  output wire        end_irq_request_o
);

  // Standby clears the block exactly as reset does
  wire       clr = rst_i | standby_i; // [R20]

  reg        conv_end_flag;
  reg        end_irq_enable;
  reg        conv_start_bit;
  reg        scan_mode;
  reg        conv_speed_select;
  reg        group_select_bit;
  reg  [1:0] channel_select;
  reg        ext_trigger_enable;
  reg        flag_seen;
  reg        trig_pin_prev;
  reg  [1:0] state;
  reg  [4:0] sync_cnt;
  reg  [1:0] scan_idx;
  reg  [9:0] result_mem [0:3];
  reg  [7:0] low_temp;
  reg        next_start;
  integer    i;

  wire       eng_done;
  wire [9:0] eng_result;
  wire       trig_fall = ext_trigger_enable && trig_pin_prev && !ext_trigger_pin_n_i; // [R15]
  wire       start_rise = next_start && !conv_start_bit;
  wire       stop = conv_start_bit && !next_start;
  wire       cur_done = (state == `ADCSEQ_ST_CONV) && eng_done;
  wire [1:0] cur_slot = scan_mode ? scan_idx : channel_select;
  wire       last_slot = (scan_idx == channel_select);
  wire       pass_end = cur_done && (!scan_mode || last_slot);
  wire       sync_end = (state == `ADCSEQ_ST_SYNC) && (sync_cnt == 5'h01);
  // Next scan channel starts on the same edge the previous one ends
  wire       eng_start = sync_end || (cur_done && scan_mode && !stop); // [R8]
  wire       eng_abort = stop && !cur_done; // [R21]

  // Stored low bits sit in bits 7-6 with zero padding below
  function [7:0] low_byte;
    input [9:0] r;
    begin
      low_byte = {r[1:0], `ADCSEQ_LOW_PAD}; // [R17]
    end
  endfunction

  assign conv_control_status_reg_o = {conv_end_flag, end_irq_enable, conv_start_bit, scan_mode,
                                      conv_speed_select, group_select_bit, channel_select};
  assign trigger_control_reg_o = {ext_trigger_enable, `ADCSEQ_TRG_RESERVED};
  assign conv_start_bit_o      = conv_start_bit;
  assign conv_end_flag_o       = conv_end_flag;
  assign end_irq_request_o     = conv_end_flag && end_irq_enable; // [R3]
  assign analog_sel_o          = {group_select_bit, cur_slot}; // [R19]

  // Start bit: write or trigger sets, single completion clears, a write of zero stops
  always @* begin
    next_start = conv_start_bit;
    if (cur_done && !scan_mode) begin
      next_start = 1'b0; // [R2] [R5]
    end
    if (ctrl_write_i) begin
      next_start = ctrl_wdata_i[`ADCSEQ_CSR_START]; // [R6]
    end
    if (trig_fall) begin
      next_start = 1'b1; // [R16]
    end
  end

  always @(posedge sys_clk_i) begin
    if (clr) begin
      conv_end_flag      <= 1'b0;
      end_irq_enable     <= 1'b0;
      conv_start_bit     <= 1'b0;
      scan_mode          <= 1'b0;
      conv_speed_select  <= 1'b0;
      group_select_bit   <= 1'b0;
      channel_select     <= 2'h0;
      ext_trigger_enable <= 1'b0;
      flag_seen          <= 1'b0;
      trig_pin_prev      <= 1'b1;
    end else begin
      conv_start_bit <= next_start;
      trig_pin_prev  <= ext_trigger_pin_n_i;
      if (trig_write_i) begin
        ext_trigger_enable <= trig_wdata_i[`ADCSEQ_TRG_ENABLE];
      end
      if (ctrl_write_i) begin
        end_irq_enable    <= ctrl_wdata_i[`ADCSEQ_CSR_IRQ_EN];
        scan_mode         <= ctrl_wdata_i[`ADCSEQ_CSR_SCAN];
        conv_speed_select <= ctrl_wdata_i[`ADCSEQ_CSR_SPEED];
        group_select_bit  <= ctrl_wdata_i[`ADCSEQ_CSR_GROUP];
        channel_select    <= ctrl_wdata_i[`ADCSEQ_CSR_CH_HI:`ADCSEQ_CSR_CH_LO];
      end
      // Clear needs a prior read that saw the flag; a new end event wins over the clear
      if (ctrl_read_i && conv_end_flag) begin
        flag_seen <= 1'b1;
      end
      if (pass_end) begin
        conv_end_flag <= 1'b1; // [R3] [R9]
      end else if (ctrl_write_i && !ctrl_wdata_i[`ADCSEQ_CSR_END_FLAG] && flag_seen) begin
        conv_end_flag <= 1'b0; // [R4]
        flag_seen     <= 1'b0;
      end
    end
  end

  // Sequencer
  always @(posedge sys_clk_i) begin
    if (clr) begin
      state    <= `ADCSEQ_ST_IDLE;
      sync_cnt <= 5'h00;
      scan_idx <= 2'h0;
    end else if (start_rise) begin
      // Any fresh scan start begins at the group's first channel
      state    <= `ADCSEQ_ST_SYNC;
      sync_cnt <= next_speed_sync(ctrl_write_i ? ctrl_wdata_i[`ADCSEQ_CSR_SPEED] : conv_speed_select); // [R11]
      scan_idx <= 2'h0; // [R7] [R10]
    end else if (stop) begin
      state <= `ADCSEQ_ST_IDLE; // [R10] [R21]
    end else begin
      case (state)
        `ADCSEQ_ST_IDLE: begin
          state <= `ADCSEQ_ST_IDLE;
        end
        `ADCSEQ_ST_SYNC: begin
          sync_cnt <= sync_cnt - 5'h01;
          if (sync_end) begin
            state <= `ADCSEQ_ST_CONV; // [R13]
          end
        end
        `ADCSEQ_ST_CONV: begin
          if (cur_done) begin
            if (!scan_mode) begin
              state <= `ADCSEQ_ST_IDLE; // [R5]
            end else begin
              scan_idx <= last_slot ? 2'h0 : scan_idx + 2'h1; // [R8] [R9]
            end
          end
        end
        default: begin
          state <= `ADCSEQ_ST_IDLE;
        end
      endcase
    end
  end

  function [4:0] next_speed_sync;
    input fast;
    begin
      next_speed_sync = fast ? `ADCSEQ_SYNC_FAST : `ADCSEQ_SYNC_SLOW;
    end
  endfunction

  // Result registers and byte read path
  always @(posedge sys_clk_i) begin
    if (clr) begin
      for (i = 0; i < 4; i = i + 1) begin
        result_mem[i] <= `ADCSEQ_RES_RESET; // [R20]
      end
      low_temp      <= 8'h00;
      result_byte_o <= 8'h00;
    end else begin
      if (cur_done) begin
        result_mem[cur_slot] <= eng_result; // [R5] [R8]
      end
      if (result_read_i) begin
        if (result_upper_i) begin
          result_byte_o <= result_mem[result_sel_i][9:2]; // [R17] [R18]
          low_temp      <= low_byte(result_mem[result_sel_i]); // [R18]
        end else begin
          result_byte_o <= low_temp; // [R18]
        end
      end
    end
  end

  adcseq_sar u_sar (
    .sys_clk_i     (sys_clk_i),
    .rst_i         (clr),
    .start_i       (eng_start),
    .abort_i       (eng_abort),
    .speed_i       (conv_speed_select), // [R12] [R14]
    .comp_gt_i     (comp_gt_i), // [R1]
    .sample_hold_o (sample_hold_o),
    .dac_code_o    (dac_code_o),
    .done_o        (eng_done),
    .result_o      (eng_result)
  );

endmodule // adcseq_top

`default_nettype wire

// [verification/adcseq_top_props.sv]
// Port checker for the converter control sequencer
`timescale 1ns/1ps
`default_nettype none
module adcseq_top_props (
  input wire logic       sys_clk_i,
  input wire logic       rst_i,
  input wire logic       standby_i,
  input wire logic       ctrl_write_i,
  input wire logic [7:0] ctrl_wdata_i,
  input wire logic [7:0] conv_control_status_reg_o,
  input wire logic [7:0] trigger_control_reg_o,
  input wire logic [2:0] analog_sel_o,
  input wire logic       sample_hold_o,
  input wire logic       conv_start_bit_o,
  input wire logic       conv_end_flag_o,
  input wire logic       end_irq_request_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i || standby_i);
  logic [7:0] hold_cnt;
  wire        fast = conv_control_status_reg_o[3];
  wire        scan = conv_control_status_reg_o[4];
  // Counter instead of an 80-long repetition keeps the tools fast
  always @(posedge sys_clk_i) hold_cnt <= sample_hold_o ? hold_cnt + 8'h01 : 8'h00;
  // Cycles the start bit has stayed set, saturating; a stop and restart excuses a late next window
  logic [8:0] since_high;
  always @(posedge sys_clk_i) begin
    if (!conv_start_bit_o) since_high <= 9'h000;
    else if (since_high != 9'h1FF) since_high <= since_high + 9'h001;
  end
  a_irq_follows: assert property (end_irq_request_o == (conv_end_flag_o && conv_control_status_reg_o[6]))
    else $error("irq request not flag and enable");
  a_status_bits: assert property (conv_control_status_reg_o[7] == conv_end_flag_o
    && conv_control_status_reg_o[5] == conv_start_bit_o) else $error("status bits disagree");
  a_trig_reserved: assert property (trigger_control_reg_o[6:0] == 7'h7F) else $error("reserved bits not one");
  a_flag_cause: assert property ($rose(conv_end_flag_o) |-> $past(conv_start_bit_o))
    else $error("flag set while idle");
  a_flag_clear: assert property ($fell(conv_end_flag_o) && !$past(rst_i || standby_i)
    |-> $past(ctrl_write_i) && !$past(ctrl_wdata_i[7])) else $error("flag cleared without write");
  a_single_stop: assert property ($fell(conv_start_bit_o) && !$past(ctrl_write_i) && !$past(rst_i || standby_i)
    |-> conv_end_flag_o) else $error("start cleared without end flag");
  a_scan_first: assert property ($rose(conv_start_bit_o) && scan
    |-> analog_sel_o == {conv_control_status_reg_o[2], 2'b00}) else $error("scan start channel wrong");
  a_sync_delay: assert property ($rose(conv_start_bit_o) && !fast
    |-> !sample_hold_o [*8] ##[2:9] sample_hold_o) else $error("sampling delay out of range");
  a_sync_fast: assert property ($rose(conv_start_bit_o) && fast
    |-> !sample_hold_o [*4] ##[2:5] (sample_hold_o || !conv_start_bit_o))
    else $error("fast sampling delay out of range");
  a_sample_len: assert property ($fell(sample_hold_o) && conv_start_bit_o
    |-> hold_cnt == (fast ? 8'h28 : 8'h50)) else $error("sample window length wrong");
  a_scan_period: assert property ($rose(sample_hold_o) && scan && fast
    |-> ##128 ($rose(sample_hold_o) || !conv_start_bit_o || since_high < 9'h080))
    else $error("scan period wrong");
  a_scan_slow: assert property ($rose(sample_hold_o) && scan && !fast
    |-> ##256 ($rose(sample_hold_o) || !conv_start_bit_o || since_high < 9'h100))
    else $error("slow scan period wrong");
endmodule // adcseq_top_props
bind adcseq_top adcseq_top_props adcseq_top_props_i (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .standby_i(standby_i),
  .ctrl_write_i(ctrl_write_i), .ctrl_wdata_i(ctrl_wdata_i), .conv_control_status_reg_o(conv_control_status_reg_o),
  .trigger_control_reg_o(trigger_control_reg_o), .analog_sel_o(analog_sel_o), .sample_hold_o(sample_hold_o),
  .conv_start_bit_o(conv_start_bit_o), .conv_end_flag_o(conv_end_flag_o), .end_irq_request_o(end_irq_request_o));
`default_nettype wire

// [verification/adcseq_ain.sv]
// Analog input model: fixed level per channel, ideal comparator
`timescale 1ns/1ps
`default_nettype none
module adcseq_ain (
  input  wire logic [2:0] sel_i,
  input  wire logic [9:0] dac_i,
  output var  logic       gt_o
);
  // Levels differ in several bits per channel so a wrong channel shows
  wire [9:0] level = 10'h0A5 + {7'h00, sel_i} * 10'h071;
  always_comb gt_o = (level >= dac_i);
endmodule // adcseq_ain
`default_nettype wire

// [verification/tb.sv]
// Self-checking bench for the converter control sequencer
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic       sys_clk_i = 1'b0, rst_i = 1'b1, standby_i = 1'b0, ctrl_write_i = 1'b0, ctrl_read_i = 1'b0;
  logic       trig_write_i = 1'b0, result_read_i = 1'b0, result_upper_i = 1'b0, ext_trigger_pin_n_i = 1'b1;
  logic [7:0] ctrl_wdata_i = 8'h00, trig_wdata_i = 8'h00;
  logic [1:0] result_sel_i = 2'h0;
  wire        comp_gt_i, sample_hold_o, conv_start_bit_o, conv_end_flag_o, end_irq_request_o;
  wire  [7:0] csr, trig, rbyte;
  wire  [2:0] analog_sel_o;
  wire  [9:0] dac_code_o;
  int         fail_count = 0, n_checks = 0, cyc = 0, t0;
  adcseq_top adcseq_top_i (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .standby_i(standby_i), .ctrl_write_i(ctrl_write_i),
    .ctrl_wdata_i(ctrl_wdata_i), .ctrl_read_i(ctrl_read_i), .conv_control_status_reg_o(csr),
    .trig_write_i(trig_write_i), .trig_wdata_i(trig_wdata_i), .trigger_control_reg_o(trig),
    .result_read_i(result_read_i), .result_sel_i(result_sel_i), .result_upper_i(result_upper_i),
    .result_byte_o(rbyte), .ext_trigger_pin_n_i(ext_trigger_pin_n_i), .comp_gt_i(comp_gt_i),
    .analog_sel_o(analog_sel_o), .sample_hold_o(sample_hold_o), .dac_code_o(dac_code_o),
    .conv_start_bit_o(conv_start_bit_o), .conv_end_flag_o(conv_end_flag_o), .end_irq_request_o(end_irq_request_o));
  adcseq_ain adcseq_ain_i (.sel_i(analog_sel_o), .dac_i(dac_code_o), .gt_o(comp_gt_i));
  always #2.5 sys_clk_i = ~sys_clk_i;
  task wrap_up;
    $display("errors %0d checks %0d", fail_count, n_checks);
    if (fail_count == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Whole run needs about 2100 cycles
  always @(posedge sys_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      fail_count++;
      wrap_up();
    end
  end
  task chk(input logic [9:0] got, input logic [9:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  function automatic logic [9:0] lvl(input logic [2:0] c);
    return 10'h0A5 + {7'h00, c} * 10'h071;
  endfunction
  task wr(input logic [7:0] d);
    @(posedge sys_clk_i) ctrl_write_i <= 1'b1;
    ctrl_wdata_i <= d;
    @(posedge sys_clk_i) ctrl_write_i <= 1'b0;
    #1;
  endtask
  task rcsr;
    @(posedge sys_clk_i) ctrl_read_i <= 1'b1;
    @(posedge sys_clk_i) ctrl_read_i <= 1'b0;
  endtask
  task rres(input logic [1:0] s, input logic u);
    @(posedge sys_clk_i) result_read_i <= 1'b1;
    result_sel_i <= s;
    result_upper_i <= u;
    @(posedge sys_clk_i) result_read_i <= 1'b0;
    #1;
  endtask
  task res_chk(input logic [1:0] s, input logic [9:0] v);
    rres(s, 1'b1);
    chk(rbyte, v[9:2]);
    rres(s, 1'b0);
    chk(rbyte, {v[1:0], 6'h00});
  endtask
  task wait_for(input logic flag, input logic v);
    for (int i = 0; i < 1200 && (flag ? conv_end_flag_o : conv_start_bit_o) !== v; i++) begin
      @(posedge sys_clk_i);
      #1;
    end
  endtask
  task t_reset;
    chk(csr, 8'h00);
    chk(trig, 8'h7F);
    for (int s = 0; s < 4; s++) res_chk(s[1:0], 10'h000);
  endtask
  task t_single;
    wr(8'h61);
    t0 = cyc;
    chk(conv_start_bit_o, 1'b1);
    chk(analog_sel_o, 3'h1);
    wait_for(1'b0, 1'b0);
    chk((cyc - t0) inside {[259:266]}, 1'b1);
    chk(csr, 8'hC1);
    chk(end_irq_request_o, 1'b1);
    wr(8'h41);
    chk(conv_end_flag_o, 1'b1);
    rcsr();
    wr(8'h41);
    chk(conv_end_flag_o, 1'b0);
    res_chk(2'h1, lvl(3'h1));
  endtask
  task t_abort;
    wr(8'h23);
    repeat (50) @(posedge sys_clk_i);
    wr(8'h03);
    repeat (300) @(posedge sys_clk_i);
    #1;
    chk(conv_end_flag_o, 1'b0);
    res_chk(2'h3, 10'h000);
  endtask
  task t_scan;
    wr(8'h3E);
    t0 = cyc;
    chk(analog_sel_o, 3'h4);
    wait_for(1'b1, 1'b1);
    chk((cyc - t0) inside {[387:390]}, 1'b1);
    chk({conv_start_bit_o, analog_sel_o}, 4'hC);
    for (int s = 0; s < 3; s++) res_chk(s[1:0], lvl(3'h4 + s[2:0]));
    res_chk(2'h3, 10'h000);
    repeat (200) @(posedge sys_clk_i);
    wr(8'h1E);
    chk(conv_start_bit_o, 1'b0);
    wr(8'h3E);
    chk(analog_sel_o, 3'h4);
    rcsr();
    wr(8'h02);
    chk(conv_end_flag_o, 1'b0);
  endtask
  task fire_trig;
    @(posedge sys_clk_i) ext_trigger_pin_n_i <= 1'b0;
    @(posedge sys_clk_i) ext_trigger_pin_n_i <= 1'b1;
    #1;
  endtask
  task t_trig;
    @(posedge sys_clk_i) trig_write_i <= 1'b1;
    trig_wdata_i <= 8'h80;
    @(posedge sys_clk_i) trig_write_i <= 1'b0;
    ext_trigger_pin_n_i <= 1'b0;
    @(posedge sys_clk_i) ext_trigger_pin_n_i <= 1'b1;
    #1;
    chk(trig, 8'hFF);
    chk(conv_start_bit_o, 1'b1);
    wait_for(1'b0, 1'b0);
    chk(conv_end_flag_o, 1'b1);
    res_chk(2'h2, lvl(3'h2));
    // Slow scan of inputs 0 and 1, started from the pin this time
    rcsr();
    wr(8'h11);
    chk(conv_end_flag_o, 1'b0);
    fire_trig();
    t0 = cyc;
    chk(conv_start_bit_o, 1'b1);
    wait_for(1'b1, 1'b1);
    chk((cyc - t0) inside {[515:522]}, 1'b1);
    chk({conv_start_bit_o, analog_sel_o}, 4'h8);
    res_chk(2'h0, lvl(3'h0));
    res_chk(2'h1, lvl(3'h1));
    wr(8'h11);
    chk(conv_start_bit_o, 1'b0);
    chk(conv_end_flag_o, 1'b1);
  endtask
  initial begin
    repeat (8) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    #1;
    t_reset();
    t_single();
    t_abort();
    t_scan();
    t_trig();
    @(posedge sys_clk_i) standby_i <= 1'b1;
    @(posedge sys_clk_i) standby_i <= 1'b0;
    #1;
    t_reset();
    wrap_up();
  end
endmodule // tb
`default_nettype wire
